// *** sysclk_pkg.sv ***
// Package for the system clock select block: source codes, unlock keys, timing counts.
// Assumes a single 25 MHz system clock domain with an active-low asynchronous reset.
package sysclk_pkg;

  // ----------------------------------------------------------------
  // Clock source selection
  // ----------------------------------------------------------------
  typedef enum logic [1:0]
  {
    SYSCLK_SRC_RC   = 2'b00,
    SYSCLK_SRC_EXT  = 2'b01,
    SYSCLK_SRC_WDOG = 2'b10
  } sysclk_src_type;

  // ----------------------------------------------------------------
  // Control register layout and reset value
  // ----------------------------------------------------------------
  localparam int             CTL_W          = 8;
  localparam int             CTL_RC_EN_BIT  = 7;
  localparam int             CTL_RC_LOW_BIT = 6;
  localparam int             CTL_FAIL_EN_BIT= 5;
  localparam int             CTL_SRC_LSB    = 0;
  localparam logic [7:0]     CTL_RESET      = 8'hA0;
  localparam logic [7:0]     UNLOCK_KEY1    = 8'hE7;
  localparam logic [7:0]     UNLOCK_KEY2    = 8'h18;

  // ----------------------------------------------------------------
  // Oscillator frequencies and failure timeout
  // ----------------------------------------------------------------
  localparam int             RC_FAST_KHZ    = 5530;
  localparam int             RC_SLOW_HZ     = 32800;
  localparam int             SYS_CLK_KHZ    = 25000;
  localparam int             FAIL_TIME_US   = 100;
  localparam int             FAIL_CYCLES    = FAIL_TIME_US * SYS_CLK_KHZ / 1000;
  localparam int             SYNC_STAGES    = 2;

endpackage : sysclk_pkg

// *** sysclk_edge_mon.sv ***
// Activity monitor: flags a clock source as failed when no edge is seen for a timeout.
// Assumes the monitored signal is already synchronous to CLK_SYS_I.
`timescale 1ns/1ps
module sysclk_edge_mon #(
  parameter int TIMEOUT = sysclk_pkg::FAIL_CYCLES
)(
  input  wire logic clk_i,     // System clock.
  input  wire logic reset_n_i, // Asynchronous reset, active low.
  input  wire logic ce_i,      // Clock enable.
  input  wire logic mon_i,     // Synchronised source level.
  output logic      fail_o     // Source seen stalled.
);

  typedef struct packed
  {
    logic        last;
    logic [15:0] cnt;
    logic        fail;
  } sysclk_mon_type;

  sysclk_mon_type st_r;
  sysclk_mon_type st_nxt;

  always_comb
  begin
    st_nxt      = st_r;
    st_nxt.last = mon_i;
    if (mon_i != st_r.last)
    begin
      st_nxt.cnt  = 16'h0000;
      st_nxt.fail = 1'b0;
    end
    else if (st_r.cnt == 16'(TIMEOUT - 1))
      st_nxt.fail = 1'b1;
    else
      st_nxt.cnt = st_r.cnt + 16'h0001;
  end

  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      st_r <= '0;
    else if (ce_i)
      st_r <= st_nxt;
  end

  assign fail_o = st_r.fail;

endmodule : sysclk_edge_mon

// *** sysclk_select.sv ***
// Holds the osc_select_control_reg, unlock logic, failure fallback and glitch-free clock mux.
// Assumes all source clocks are sampled as synchronous inputs to CLK_SYS_I.
`timescale 1ns/1ps
module sysclk_select (
  input  wire logic       CLK_SYS_I,     // 25 MHz system clock.
  input  wire logic       RESET_N_I,     // Asynchronous reset, active low.
  input  wire logic       CE_I,          // Clock enable, freezes state when low.
  input  wire logic       WR_I,          // Control write strobe.
  input  wire logic [7:0] WDATA_I,       // Control write data.
  input  wire logic       RC_CLK_I,      // Trimmed RC oscillator output.
  input  wire logic       EXT_CLK_I,     // Clock on port_b_bit3_pin.
  input  wire logic       WDOG_CLK_I,    // Watchdog oscillator output.
  input  wire logic       WDOG_RUN_I,    // Watchdog oscillator running.
  output logic            SYS_CLK_O,     // Selected system clock.
  output logic [7:0]      CTL_O,         // Control register readback.
  output logic            UNLOCKED_O,    // Register unlocked.
  output logic            RC_EN_O,       // RC oscillator enable.
  output logic            RC_LOW_O,      // RC at 32.8 kHz when high, 5.53 MHz when low.
  output logic [1:0]      ACT_SRC_O,     // Source now driving the clock.
  output logic            FAIL_O         // Primary failure detected.
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef enum logic [1:0]
  {
    LK_LOCKED = 2'b00,
    LK_KEY1   = 2'b01,
    LK_OPEN   = 2'b10
  } sysclk_lock_type;

  typedef struct packed
  {
    sysclk_lock_type lock;
    logic [7:0]      ctl;
    logic [1:0]      act;
    logic            hold;
    logic            fail;
    logic            clk;
    logic [2:0]      s1;
    logic [2:0]      s2;
  } sysclk_st_type;

  sysclk_st_type st_r;
  sysclk_st_type st_nxt;
  logic          ext_fail;
  logic [1:0]    want;
  logic          mon_sel;

  // ----------------------------------------------------------------
  // Failure detection on the primary sources
  // ----------------------------------------------------------------
  sysclk_edge_mon #(
    .TIMEOUT (sysclk_pkg::FAIL_CYCLES)
  ) u_mon (
    .clk_i     (CLK_SYS_I),
    .reset_n_i (RESET_N_I),
    .ce_i      (CE_I),
    .mon_i     (mon_sel),
    .fail_o    (ext_fail)
  );

  // The RC source is watched while it drives the clock, otherwise the pin clock.
  assign mon_sel = (st_r.act == sysclk_pkg::SYSCLK_SRC_RC) ? st_r.s2[0] : st_r.s2[1];

  // ----------------------------------------------------------------
  // Unlock sequence, control register and clock switch
  // ----------------------------------------------------------------
  always_comb
  begin
    st_nxt    = st_r;
    st_nxt.s1 = {WDOG_CLK_I, EXT_CLK_I, RC_CLK_I};
    st_nxt.s2 = st_r.s1;
    case (st_r.lock)
      LK_LOCKED:
        if (WR_I && WDATA_I == sysclk_pkg::UNLOCK_KEY1)
          st_nxt.lock = LK_KEY1;
      LK_KEY1:
        if (WR_I)
          st_nxt.lock = (WDATA_I == sysclk_pkg::UNLOCK_KEY2) ? LK_OPEN : LK_LOCKED;
      LK_OPEN:
        if (WR_I)
        begin
          st_nxt.ctl  = WDATA_I;
          st_nxt.lock = LK_LOCKED;
          st_nxt.fail = 1'b0;
        end
      default:
        st_nxt.lock = LK_LOCKED;
    endcase
    // A primary stall forces the watchdog oscillator; a write to the unlocked register clears it.
    if (ext_fail && st_r.ctl[sysclk_pkg::CTL_FAIL_EN_BIT] && st_r.act != sysclk_pkg::SYSCLK_SRC_WDOG)
      st_nxt.fail = 1'b1;
    want = st_r.fail ? sysclk_pkg::SYSCLK_SRC_WDOG : st_r.ctl[1:0];
    if (want == 2'b11)
      want = sysclk_pkg::SYSCLK_SRC_RC;
    // Glitch-free switch: the high phase of the old source is allowed to finish,
    // the source changes while the output is low, and the output then stays low
    // until the new source is seen low, so neither phase is cut short unless a failure is flagged.
    // A stalled source could pin the output high, so a failure forces it low.
    if (want != st_r.act)
    begin
      if (!st_r.clk)
      begin
        st_nxt.act  = want;
        st_nxt.hold = 1'b1;
        st_nxt.clk  = 1'b0;
      end
      else if (st_r.fail)
        st_nxt.clk = 1'b0;
      else
        st_nxt.clk = st_r.s2[st_r.act];
    end
    else if (st_r.hold)
    begin
      st_nxt.clk = 1'b0;
      if (!st_r.s2[st_r.act])
        st_nxt.hold = 1'b0;
    end
    else if (st_r.clk == 1'b0 || st_r.s2[st_r.act] == 1'b0)
      st_nxt.clk = st_r.s2[st_r.act] &
                   (st_r.act != sysclk_pkg::SYSCLK_SRC_RC | st_r.ctl[sysclk_pkg::CTL_RC_EN_BIT]);
    else
      st_nxt.clk = st_r.s2[st_r.act];
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------

  always_ff @(posedge CLK_SYS_I or negedge RESET_N_I)
  begin
    if (!RESET_N_I)
    begin
      st_r      <= '0;
      st_r.ctl  <= sysclk_pkg::CTL_RESET;
      st_r.lock <= LK_LOCKED;
    end
    else if (CE_I)
      st_r <= st_nxt;
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign SYS_CLK_O  = st_r.clk;
  assign CTL_O      = st_r.ctl;
  assign UNLOCKED_O = (st_r.lock == LK_OPEN);
  assign RC_EN_O    = st_r.ctl[sysclk_pkg::CTL_RC_EN_BIT];
  assign RC_LOW_O   = st_r.ctl[sysclk_pkg::CTL_RC_LOW_BIT];
  assign ACT_SRC_O  = st_r.act;
  assign FAIL_O     = st_r.fail;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  a_locked_write: assert property (@(posedge CLK_SYS_I) disable iff (!RESET_N_I)
    CE_I && WR_I && st_r.lock != LK_OPEN |=> $stable(CTL_O))
    else $error("control changed without unlock");
  a_relock_after: assert property (@(posedge CLK_SYS_I) disable iff (!RESET_N_I)
    CE_I && WR_I && st_r.lock == LK_OPEN |=> !UNLOCKED_O && CTL_O == $past(WDATA_I))
    else $error("no relock after write");
  a_switch_low: assert property (@(posedge CLK_SYS_I) disable iff (!RESET_N_I)
    $changed(ACT_SRC_O) |-> $past(SYS_CLK_O) == 1'b0)
    else $error("source switched while clock high");
  a_fail_wdog: assert property (@(posedge CLK_SYS_I) disable iff (!RESET_N_I)
    CE_I && FAIL_O && !WR_I |-> ##[0:4] ACT_SRC_O == sysclk_pkg::SYSCLK_SRC_WDOG)
    else $error("no fallback to watchdog");
  a_src_legal: assert property (@(posedge CLK_SYS_I) disable iff (!RESET_N_I)
    ACT_SRC_O != 2'b11)
    else $error("illegal source");
  a_rc_off_low: assert property (@(posedge CLK_SYS_I) disable iff (!RESET_N_I)
    CE_I && !RC_EN_O && ACT_SRC_O == sysclk_pkg::SYSCLK_SRC_RC && !SYS_CLK_O |=> !SYS_CLK_O)
    else $error("disabled RC drives clock");
  a_ext_follow: assert property (@(posedge CLK_SYS_I) disable iff (!RESET_N_I)
    CE_I && ACT_SRC_O == sysclk_pkg::SYSCLK_SRC_EXT && $stable(ACT_SRC_O) && !FAIL_O
    && !st_r.hold && st_r.ctl[1:0] == sysclk_pkg::SYSCLK_SRC_EXT |=> SYS_CLK_O == $past(st_r.s2[1]))
    else $error("external clock not followed");
  a_key_seq: assert property (@(posedge CLK_SYS_I) disable iff (!RESET_N_I)
    $rose(UNLOCKED_O) |-> $past(st_r.lock) == LK_KEY1 && $past(WDATA_I) == sysclk_pkg::UNLOCK_KEY2)
    else $error("unlocked without keys");
  a_hold_low: assert property (@(posedge CLK_SYS_I) disable iff (!RESET_N_I)
    CE_I && st_r.hold |=> !SYS_CLK_O)
    else $error("clock rose while waiting for new source");
  a_high_kept: assert property (@(posedge CLK_SYS_I) disable iff (!RESET_N_I)
    CE_I && SYS_CLK_O && !FAIL_O && st_r.s2[st_r.act] |=> SYS_CLK_O)
    else $error("high phase cut short");
  a_fail_set: assert property (@(posedge CLK_SYS_I) disable iff (!RESET_N_I)
    CE_I && ext_fail && CTL_O[sysclk_pkg::CTL_FAIL_EN_BIT] && ACT_SRC_O != sysclk_pkg::SYSCLK_SRC_WDOG |=> FAIL_O)
    else $error("failure not flagged");
  a_fail_sticky: assert property (@(posedge CLK_SYS_I) disable iff (!RESET_N_I)
    CE_I && FAIL_O && !(WR_I && st_r.lock == LK_OPEN) |=> FAIL_O)
    else $error("failure flag dropped");
  a_ctl_stable: assert property (@(posedge CLK_SYS_I) disable iff (!RESET_N_I)
    CE_I && !WR_I |=> $stable(CTL_O))
    else $error("control changed without write");
  a_key1_only: assert property (@(posedge CLK_SYS_I) disable iff (!RESET_N_I)
    CE_I && WR_I && st_r.lock == LK_LOCKED |=> !UNLOCKED_O)
    else $error("unlocked by one write");
  a_freeze_state: assert property (@(posedge CLK_SYS_I) disable iff (!RESET_N_I)
    !CE_I |=> $stable(SYS_CLK_O) && $stable(ACT_SRC_O) && $stable(CTL_O))
    else $error("state moved while clock enable low");

  // ----------------------------------------------------------------
  // Cover points
  // ----------------------------------------------------------------
  c_unlock: cover property (@(posedge CLK_SYS_I) $rose(UNLOCKED_O));
  c_code3: cover property (@(posedge CLK_SYS_I) ACT_SRC_O == sysclk_pkg::SYSCLK_SRC_RC && CTL_O[1:0] == 2'b11);
  c_rc_off: cover property (@(posedge CLK_SYS_I) !RC_EN_O && ACT_SRC_O == sysclk_pkg::SYSCLK_SRC_RC);
  c_to_ext: cover property (@(posedge CLK_SYS_I) ACT_SRC_O == sysclk_pkg::SYSCLK_SRC_EXT);
  c_fail: cover property (@(posedge CLK_SYS_I) $rose(FAIL_O));

endmodule : sysclk_select

// *** scs_ext_drv.sv ***
// External clock driver model on port_b_bit3_pin.
// Assumes the pin is already routed to its clock function and toggles off the falling edge.
`timescale 1ns/1ps
module scs_ext_drv #(
  parameter int HALF = 3
)(
  input  wire logic clk_i,     // Reference clock.
  input  wire logic run_i,     // Oscillator running.
  output logic      ext_clk_o  // Clock onto the pin.
);
  int cnt = 0;
  initial ext_clk_o = 1'b0;
  // A stopped source holds its level, which is how a failed oscillator looks.
  always @(negedge clk_i)
  begin
    if (run_i)
    begin
      cnt <= (cnt == HALF - 1) ? 0 : cnt + 1;
      if (cnt == HALF - 1)
        ext_clk_o <= ~ext_clk_o;
    end
  end
endmodule : scs_ext_drv

// *** tb.sv ***
// Testbench for the system clock select block.
// Assumes scs_ext_drv as the pin-side clock and a 25 MHz system clock.
`timescale 1ns/1ps
module tb;
  logic       clk = 1'b0;
  logic       rst_n = 1'b0;
  logic       ce = 1'b1;
  logic       wr = 1'b0;
  logic [7:0] wdata = 8'h00;
  logic [1:0] rc_cnt = 2'h0;
  logic       wd_clk = 1'b0;
  int         wd_cnt = 0;
  logic       ext_run = 1'b1;
  logic       ext_clk, sys_clk, unl, rc_en, rc_low, fail;
  logic [7:0] ctl;
  logic [1:0] src;
  int         error_cnt = 0;
  int         total_checks = 0;
  always #20 clk = ~clk;
  always @(negedge clk)
  begin
    rc_cnt <= rc_cnt + 2'h1;
    wd_cnt <= (wd_cnt == 4) ? 0 : wd_cnt + 1;
    if (wd_cnt == 4)
      wd_clk <= ~wd_clk;
  end
  scs_ext_drv #(.HALF(3)) EXT (.clk_i(clk), .run_i(ext_run), .ext_clk_o(ext_clk));
  sysclk_select DUT (.CLK_SYS_I(clk), .RESET_N_I(rst_n), .CE_I(ce), .WR_I(wr), .WDATA_I(wdata),
    .RC_CLK_I(rc_cnt[1]), .EXT_CLK_I(ext_clk), .WDOG_CLK_I(wd_clk), .WDOG_RUN_I(1'b1),
    .SYS_CLK_O(sys_clk), .CTL_O(ctl), .UNLOCKED_O(unl), .RC_EN_O(rc_en), .RC_LOW_O(rc_low),
    .ACT_SRC_O(src), .FAIL_O(fail));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    total_checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("unexpected at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk
  task automatic unlock_wr(input logic [7:0] k2, input logic [7:0] d, input logic eu);
    @(negedge clk);
    wr = 1'b1;
    wdata = sysclk_pkg::UNLOCK_KEY1;
    @(negedge clk);
    wdata = k2;
    @(negedge clk);
    wdata = d;
    chk({7'h00, unl}, {7'h00, eu}, "unlock");
    @(negedge clk);
    wr = 1'b0;
    chk({7'h00, unl}, 8'h00, "relock");
  endtask : unlock_wr
  task automatic wait_src(input logic [1:0] e);
    for (int i = 0; i < 50 && src !== e; i++)
      @(negedge clk);
    chk({6'h00, src}, {6'h00, e}, "source");
  endtask : wait_src
  task automatic rate(input int lo, input int hi);
    logic prev;
    int   n;
    n = 0;
    prev = sys_clk;
    repeat (60)
    begin
      @(negedge clk);
      if (sys_clk === 1'b1 && prev === 1'b0)
        n++;
      prev = sys_clk;
    end
    chk({7'h00, n >= lo && n <= hi}, 8'h01, "edge rate");
  endtask : rate
  task automatic t_refused;
    ce = 1'b0;
    unlock_wr(sysclk_pkg::UNLOCK_KEY2, 8'h21, 1'b0);
    ce = 1'b1;
    unlock_wr(8'h55, 8'h22, 1'b0);
    chk(ctl, sysclk_pkg::CTL_RESET, "locked ctl");
  endtask : t_refused
  task automatic t_rc;
    unlock_wr(sysclk_pkg::UNLOCK_KEY2, 8'hC0, 1'b1);
    chk({6'h00, rc_en, rc_low}, 8'h03, "rc slow");
    wait_src(2'h0);
    rate(14, 16);
    unlock_wr(sysclk_pkg::UNLOCK_KEY2, 8'h80, 1'b1);
    chk({6'h00, rc_en, rc_low}, 8'h02, "rc fast");
  endtask : t_rc
  task automatic t_code3;
    unlock_wr(sysclk_pkg::UNLOCK_KEY2, 8'h03, 1'b1);
    chk(ctl, 8'h03, "ctl rc off");
    wait_src(2'h0);
    rate(0, 0);
    unlock_wr(sysclk_pkg::UNLOCK_KEY2, 8'h83, 1'b1);
    wait_src(2'h0);
    rate(14, 16);
  endtask : t_code3
  task automatic t_src(input logic [7:0] d, input int lo, input int hi);
    unlock_wr(sysclk_pkg::UNLOCK_KEY2, d, 1'b1);
    chk(ctl, d, "ctl");
    wait_src(d[1:0]);
    rate(lo, hi);
  endtask : t_src
  task automatic t_fail;
    t_src(8'h21, 9, 11);
    ext_run = 1'b0;
    for (int i = 0; i < 3000 && fail !== 1'b1; i++)
      @(negedge clk);
    chk({7'h00, fail}, 8'h01, "fail flag");
    wait_src(2'h2);
    ext_run = 1'b1;
    t_src(8'hA0, 14, 16);
    chk({7'h00, fail}, 8'h00, "fail clear");
  endtask : t_fail
  task automatic final_report;
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : final_report
  initial
  begin
    repeat (8) @(negedge clk);
    rst_n = 1'b1;
    chk(ctl, sysclk_pkg::CTL_RESET, "reset ctl");
    chk({2'h0, rc_en, rc_low, unl, fail, src}, 8'h20, "reset outs");
    t_refused();
    t_rc();
    t_code3();
    t_src(8'h21, 9, 11);
    t_src(8'hA2, 5, 7);
    t_fail();
    final_report();
  end
  initial
  begin
    #2000000;
    error_cnt++;
    final_report();
  end
endmodule : tb
